/* hw/fmsp_regs.vh */
// register map, field positions, reset values and timing counts of the serial port
`ifndef FMSP_REGS_VH
`define FMSP_REGS_VH

`define FMSP_ADDR_CONTROL 8'h98
`define FMSP_ADDR_DATA 8'h99
`define FMSP_CONTROL_RESET 8'h00

`define FMSP_BIT_MODE_HIGH 7
`define FMSP_BIT_MODE_LOW 6
`define FMSP_BIT_FILTER 5
`define FMSP_BIT_RX_ENABLE 4
`define FMSP_BIT_TX_NINTH 3
`define FMSP_BIT_RX_NINTH 2
`define FMSP_BIT_TX_DONE 1
`define FMSP_BIT_RX_DONE 0

`define FMSP_MODE_SHIFT 2'h0
`define FMSP_MODE_UART8 2'h1
`define FMSP_MODE_UART9_FIXED 2'h2
`define FMSP_MODE_UART9_VAR 2'h3

`define FMSP_OSC_PER_MC 4'hC
`define FMSP_MC_HALF 4'h6
`define FMSP_FIXED_DIV_FAST 2'h1
`define FMSP_FIXED_DIV_SLOW 2'h3
`define FMSP_SAMPLE_FIRST 4'h6
`define FMSP_SAMPLE_MID 4'h7
`define FMSP_SAMPLE_LAST 4'h8
`define FMSP_DIV16_LAST 4'hF
`define FMSP_SHIFT_RX_INIT 8'hFE
`define FMSP_ASYNC_RX_INIT 11'h7FF

`endif

/* hw/fmsp_rx_buffer.v */
// receive holding buffer: the second stage of the double-buffered receiver
`timescale 1ns/1ps
module fmsp_rx_buffer #(
  parameter WIDTH = 8
) (
  input wire clock,
  input wire reset,
  input wire load,
  input wire [WIDTH-1:0] load_data,
  output reg [WIDTH-1:0] read_data_q
);

  // storage is its own registered read port
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      read_data_q <= {WIDTH{1'b0}};
    end else if (load) begin
      read_data_q <= load_data;
    end
  end

endmodule

/* hw/fmsp_serial_port.v */
// four-mode serial port: control register, data buffer, shift and uart engines
//
// Notes on behaviour
// - transmit and receive run concurrently, separate rates
// - receiver double buffered; late frame loses data
// - data read gives receive; write loads transmit
// - control bits: mode, filter, enable, ninths, flags
// - mode codes: shift, uart8, uart9 fixed, uart9
// - nine-bit modes: filter drops ninth-zero frames
// - eight-bit mode: filter drops frames without stop
// - receive enable changed only by software
// - transmit ninth bit sent, software owned
// - received ninth bit or stop, software cleared
// - transmit done after last bit, software clears
// - receive done after last bit, filtered
// - data write starts transmit; falling edge receives
// - shift mode: data on rxd, clock txd
// - shift write loads marker; send one cycle later
// - send shifts right each machine cycle
// - marker position triggers final shift, done
// - shift receive loads 11111110, then receive active
// - receive shifter takes pin each machine cycle
// - zero reaching left end ends reception
// - eight-bit frame: start, eight data, stop
// - clock selects pick timer 2 or timer 1
// - sixteen-times sampling, majority of three
// - transmit starts at next divide-by-16 rollover
// - load only if done clear and qualified
`timescale 1ns/1ps
`include "fmsp_regs.vh"
module fmsp_serial_port (
  input wire clock,
  input wire reset,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata_q,
  input wire timer1_overflow,
  input wire timer2_overflow,
  input wire tx_timer_select,
  input wire rx_timer_select,
  input wire double_rate,
  input wire port3_bit0_in,
  output reg port3_bit0_out_q,
  output reg port3_bit0_oe_n_q,
  output reg port3_bit1_out_q
);

  localparam TX_IDLE = 2'h0;
  localparam TX_WAIT = 2'h1;
  localparam TX_START = 2'h2;
  localparam TX_DATA = 2'h3;
  localparam RX_IDLE = 2'h0;
  localparam RX_ARM = 2'h1;
  localparam RX_RUN = 2'h2;

  reg [7:0] ctl_q;
  reg [1:0] tx_state_q;
  reg [1:0] rx_state_q;
  reg tx_pend_q;
  reg [9:0] tx_sh_q;
  reg [3:0] tx_cnt_q;
  reg [3:0] rx_cnt_q;
  reg [10:0] rx_sh_q;
  reg [2:0] rx_votes_q;
  reg [3:0] mc_cnt_q;
  reg [1:0] fix_cnt_q;
  reg t1_half_q;
  reg [2:0] pin_sync_q;
  reg pin_q;
  reg pin_prev_q;
  reg buf_load;
  reg [7:0] buf_data;
  reg set_tx_done;
  reg set_rx_done;
  reg rx_ninth_load;
  reg rx_ninth_val;
  wire [7:0] rx_buf_q;

  wire [1:0] mode = ctl_q[`FMSP_BIT_MODE_HIGH:`FMSP_BIT_MODE_LOW];
  wire mode_shift = (mode == `FMSP_MODE_SHIFT);
  wire filter = ctl_q[`FMSP_BIT_FILTER];
  wire rx_en = ctl_q[`FMSP_BIT_RX_ENABLE];
  wire rx_done = ctl_q[`FMSP_BIT_RX_DONE];
  wire wr_ctl = sfr_wr && (sfr_addr == `FMSP_ADDR_CONTROL);
  wire wr_data = sfr_wr && (sfr_addr == `FMSP_ADDR_DATA);
  wire mc_tick = (mc_cnt_q == `FMSP_OSC_PER_MC - 4'h1);
  wire t1_tick = timer1_overflow && (double_rate || t1_half_q);
  wire fix_tick = (fix_cnt_q == (double_rate ? `FMSP_FIXED_DIV_FAST : `FMSP_FIXED_DIV_SLOW));
  // sixteen-times ticks per direction; each picks its own timer, but both take the fixed divider in uart9 fixed mode
  wire tx_var = tx_timer_select ? timer2_overflow : t1_tick;
  wire rx_var = rx_timer_select ? timer2_overflow : t1_tick;
  wire tx_tick = (mode == `FMSP_MODE_UART9_FIXED) ? fix_tick : tx_var;
  wire rx_tick = (mode == `FMSP_MODE_UART9_FIXED) ? fix_tick : rx_var;
  wire tx_roll = tx_tick && (tx_cnt_q == `FMSP_DIV16_LAST);
  wire send = mode_shift && (tx_state_q == TX_DATA);
  wire receive = mode_shift && (rx_state_q == RX_RUN);
  wire pin_fall = pin_prev_q && !pin_q;
  wire majority = (rx_votes_q[0] & rx_votes_q[1]) | (rx_votes_q[0] & rx_votes_q[2]) |
                  (rx_votes_q[1] & rx_votes_q[2]);

  // machine cycle divider and fixed-rate divider
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      mc_cnt_q <= 4'h0;
      fix_cnt_q <= 2'h0;
      t1_half_q <= 1'b0;
    end else begin
      mc_cnt_q <= mc_tick ? 4'h0 : mc_cnt_q + 4'h1;
      fix_cnt_q <= fix_tick ? 2'h0 : fix_cnt_q + 2'h1;
      if (timer1_overflow) begin
        t1_half_q <= !t1_half_q;
      end
    end
  end

  // pin synchroniser: a change counts once stages two and three agree
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      pin_sync_q <= 3'h7;
      pin_q <= 1'b1;
      pin_prev_q <= 1'b1;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], port3_bit0_in};
      if (pin_sync_q[1] == pin_sync_q[2]) begin
        pin_q <= pin_sync_q[2];
      end
      pin_prev_q <= pin_q;
    end
  end

  // transmitter; write latches a request, synchronised to the engine tick
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      tx_state_q <= TX_IDLE;
      tx_pend_q <= 1'b0;
      tx_sh_q <= 10'h000;
      tx_cnt_q <= 4'h0;
      set_tx_done <= 1'b0;
    end else begin
      set_tx_done <= 1'b0;
      if (tx_tick) begin
        tx_cnt_q <= tx_cnt_q + 4'h1;
      end
      if (wr_data) begin
        // marker sits above the data (and ninth bit in nine-bit modes)
        tx_pend_q <= 1'b1;
        if (mode_shift || mode == `FMSP_MODE_UART8) begin
          tx_sh_q <= {1'b0, 1'b1, sfr_wdata};
        end else begin
          tx_sh_q <= {1'b1, ctl_q[`FMSP_BIT_TX_NINTH], sfr_wdata};
        end
        tx_state_q <= TX_IDLE;
      end else begin
        case (tx_state_q)
          TX_IDLE: begin
            if (tx_pend_q && mode_shift && mc_tick) begin
              tx_state_q <= TX_WAIT;
              tx_pend_q <= 1'b0;
            end else if (tx_pend_q && !mode_shift && tx_roll) begin
              tx_state_q <= TX_START;
              tx_pend_q <= 1'b0;
            end
          end
          TX_WAIT: begin
            // one full machine cycle before send
            if (mc_tick) begin
              tx_state_q <= TX_DATA;
            end
          end
          TX_START: begin
            if (tx_roll) begin
              tx_state_q <= TX_DATA;
            end
          end
          TX_DATA: begin
            if (mode_shift ? mc_tick : tx_roll) begin
              tx_sh_q <= {1'b0, tx_sh_q[9:1]};
              if (mode_shift ? (tx_sh_q[9:1] == 9'h001) : (tx_sh_q[9:1] == 9'h000)) begin
                tx_state_q <= TX_IDLE;
                set_tx_done <= 1'b1;
              end
            end
          end
          default: tx_state_q <= TX_IDLE;
        endcase
      end
    end
  end

  // receiver engines for shift mode and the uart modes
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_state_q <= RX_IDLE;
      rx_sh_q <= `FMSP_ASYNC_RX_INIT;
      rx_cnt_q <= 4'h0;
      rx_votes_q <= 3'h7;
    end else begin
      case (rx_state_q)
        RX_IDLE: begin
          if (mode_shift && rx_en && !rx_done) begin
            rx_state_q <= RX_ARM;
          end else if (!mode_shift && rx_en && pin_fall) begin
            rx_state_q <= RX_RUN;
            rx_sh_q <= `FMSP_ASYNC_RX_INIT;
            rx_cnt_q <= 4'h0;
          end
        end
        RX_ARM: begin
          if (mc_tick) begin
            rx_sh_q <= {3'h7, `FMSP_SHIFT_RX_INIT};
            rx_state_q <= RX_RUN;
          end
        end
        RX_RUN: begin
          if (mode_shift) begin
            if (mc_tick) begin
              rx_sh_q[7:0] <= {rx_sh_q[6:0], pin_q};
              if (!rx_sh_q[7]) begin
                rx_state_q <= RX_IDLE;
              end
            end
          end else if (rx_tick) begin
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == `FMSP_SAMPLE_FIRST) begin
              rx_votes_q[0] <= pin_q;
            end
            if (rx_cnt_q == `FMSP_SAMPLE_MID) begin
              rx_votes_q[1] <= pin_q;
            end
            if (rx_cnt_q == `FMSP_SAMPLE_LAST + 4'h1) begin
              // false start returns to the edge search
              if (rx_sh_q == `FMSP_ASYNC_RX_INIT && majority) begin
                rx_state_q <= RX_IDLE;
              end else begin
                rx_sh_q <= {majority, rx_sh_q[10:1]};
                if ((mode == `FMSP_MODE_UART8) ? !rx_sh_q[2] : !rx_sh_q[1]) begin
                  rx_state_q <= RX_IDLE;
                end
              end
            end
          end
          if (rx_tick && !mode_shift && rx_cnt_q == `FMSP_SAMPLE_LAST) begin
            rx_votes_q[2] <= pin_q;
          end
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // completion qualifier; stale done flag or failed filter drops the frame
  always @* begin : rx_finish
    integer i;
    reg qual;
    buf_load = 1'b0;
    buf_data = 8'h00;
    rx_ninth_load = 1'b0;
    rx_ninth_val = 1'b0;
    set_rx_done = 1'b0;
    qual = 1'b0;
    i = 0;
    if (rx_state_q == RX_RUN && mode_shift && mc_tick && !rx_sh_q[7]) begin
      // first bit in sits at bit 6, the pin bit is the msb
      for (i = 0; i < 7; i = i + 1) begin
        buf_data[i] = rx_sh_q[6 - i];
      end
      buf_data[7] = pin_q;
      buf_load = !rx_done;
      set_rx_done = !rx_done;
    end else if (rx_state_q == RX_RUN && !mode_shift && rx_tick &&
                 rx_cnt_q == `FMSP_SAMPLE_LAST + 4'h1 && rx_sh_q != `FMSP_ASYNC_RX_INIT) begin
      if (mode == `FMSP_MODE_UART8 && !rx_sh_q[2]) begin
        buf_data = rx_sh_q[10:3];
        qual = majority;
        rx_ninth_val = majority;
        set_rx_done = !rx_done && (!filter || qual);
      end else if (mode != `FMSP_MODE_UART8 && !rx_sh_q[1]) begin
        buf_data = rx_sh_q[9:2];
        qual = rx_sh_q[10];
        rx_ninth_val = rx_sh_q[10];
        set_rx_done = !rx_done && (!filter || qual);
      end
      buf_load = set_rx_done;
      rx_ninth_load = set_rx_done;
    end
  end

  // second receive stage
  fmsp_rx_buffer #(
    .WIDTH(8)
  ) u_rx_buffer (
    .clock(clock),
    .reset(reset),
    .load(buf_load),
    .load_data(buf_data),
    .read_data_q(rx_buf_q)
  );

  // control register; hardware set wins over a software clear
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ctl_q <= `FMSP_CONTROL_RESET;
    end else begin
      if (wr_ctl) begin
        ctl_q <= sfr_wdata;
      end
      if (rx_ninth_load) begin
        ctl_q[`FMSP_BIT_RX_NINTH] <= rx_ninth_val;
      end
      if (set_tx_done) begin
        ctl_q[`FMSP_BIT_TX_DONE] <= 1'b1;
      end
      if (set_rx_done) begin
        ctl_q[`FMSP_BIT_RX_DONE] <= 1'b1;
      end
    end
  end

  // register read port, one cycle behind the strobe
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      sfr_rdata_q <= 8'h00;
    end else if (sfr_rd) begin
      if (sfr_addr == `FMSP_ADDR_CONTROL) begin
        sfr_rdata_q <= ctl_q;
      end else if (sfr_addr == `FMSP_ADDR_DATA) begin
        sfr_rdata_q <= rx_buf_q;
      end else begin
        sfr_rdata_q <= 8'h00;
      end
    end
  end

  // pins: shift clock low in first half of each active machine cycle
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      port3_bit0_out_q <= 1'b1;
      port3_bit0_oe_n_q <= 1'b1;
      port3_bit1_out_q <= 1'b1;
    end else if (mode_shift) begin
      port3_bit0_out_q <= send ? tx_sh_q[0] : 1'b1;
      port3_bit0_oe_n_q <= !send;
      port3_bit1_out_q <= !((send || receive) && mc_cnt_q < `FMSP_MC_HALF);
    end else begin
      port3_bit0_out_q <= 1'b1;
      port3_bit0_oe_n_q <= 1'b1;
      port3_bit1_out_q <= (tx_state_q == TX_START) ? 1'b0 :
                          (tx_state_q == TX_DATA) ? tx_sh_q[0] : 1'b1;
    end
  end

endmodule

/* test/fmsp_partner.sv */
// far-side serial device: uart frames both ways, shift-register peer in mode 0
`timescale 1ns/1ps
module fmsp_partner (
  input wire line,
  output reg rxd_drive
);
  integer bit_ns = 512;
  integer i;
  integer j;
  reg m0_on = 1'b1;
  reg [7:0] m0_byte = 8'h00;
  reg [2:0] m0_idx = 3'h0;
  reg [9:0] rx_word = 10'h000;
  initial rxd_drive = 1'b1;
  // frame: low start, nine bits lsb first, high stop, then idle like a pull-up
  task send(input [8:0] w);
    begin
      rxd_drive = 1'b0;
      #(bit_ns);
      for (i = 0; i < 9; i = i + 1) begin
        rxd_drive = w[i];
        #(bit_ns);
      end
      rxd_drive = 1'b1;
      #(bit_ns);
    end
  endtask
  // released pin floats up to the pull-up level
  always @(negedge m0_on) rxd_drive = 1'b1;
  // mode 0: new bit just after each falling shift clock; uart: sample mid-bit
  always @(negedge line) begin
    if (m0_on) begin
      #1;
      rxd_drive = m0_byte[m0_idx];
      m0_idx = m0_idx + 3'h1;
    end else begin
      #(bit_ns / 2);
      for (j = 0; j < 10; j = j + 1) begin
        #(bit_ns);
        rx_word[j] = line;
      end
    end
  end
endmodule

/* test/fmsp_sva.sv */
// assertion checker for the serial port pins and register bus
`timescale 1ns/1ps
`include "fmsp_regs.vh"
module fmsp_sva (
  input wire clock,
  input wire reset,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata_q,
  input wire port3_bit0_out_q,
  input wire port3_bit0_oe_n_q,
  input wire port3_bit1_out_q
);
  reg [7:0] ctl_q;
  reg [7:0] low_q;
  reg rd_ctl_q;
  reg rd_bad_q;
  wire sh = port3_bit1_out_q;
  wire send = !port3_bit0_oe_n_q;
  // shadow of software control writes; the design may set flags, never bits 7..3
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ctl_q <= 8'h00;
      low_q <= 8'h00;
      rd_ctl_q <= 1'b0;
      rd_bad_q <= 1'b0;
    end else begin
      if (sfr_wr && sfr_addr == `FMSP_ADDR_CONTROL) begin
        ctl_q <= sfr_wdata;
      end
      low_q <= send ? low_q + 8'h01 : 8'h00;
      rd_ctl_q <= sfr_rd && sfr_addr == `FMSP_ADDR_CONTROL;
      rd_bad_q <= sfr_rd && sfr_addr != `FMSP_ADDR_CONTROL && sfr_addr != `FMSP_ADDR_DATA;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // shift clock: six clocks low, then high
  sequence seq_low_phase;
    (!sh)[*6] ##1 sh;
  endsequence
  // send begins after one full machine cycle of waiting, seen through the pin register
  sequence seq_send_start;
    ##[15:26] $rose(send);
  endsequence
  AST_RESET_IDLE: assert property ($fell(reset) |-> !send && sh && sfr_rdata_q == 8'h00)
    else $error("pins or read data not idle after reset");
  AST_UNMAPPED_ZERO: assert property (rd_bad_q |-> sfr_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  AST_SW_BITS: assert property (rd_ctl_q |-> sfr_rdata_q[7:3] == ctl_q[7:3])
    else $error("software bits changed by hardware");
  AST_RDATA_HOLDS: assert property (!$past(sfr_rd) |-> $stable(sfr_rdata_q))
    else $error("read data moved without a read");
  AST_SEND_ONLY_MODE0: assert property (send |-> ctl_q[7:6] == `FMSP_MODE_SHIFT)
    else $error("data pin driven outside shift mode");
  AST_SEND_DELAY: assert property (sfr_wr && sfr_addr == `FMSP_ADDR_DATA && ctl_q[7:6] == 2'h0
    |-> seq_send_start)
    else $error("send not started after buffer write");
  AST_SEND_LENGTH: assert property ($fell(send) |-> low_q == 8'h60)
    else $error("send not eight machine cycles");
  AST_SHIFT_CLOCK: assert property (send && $fell(sh) |-> seq_low_phase)
    else $error("shift clock phase wrong");
  AST_DATA_STABLE: assert property (send && sh && $past(sh) |-> $stable(port3_bit0_out_q))
    else $error("data moved while shift clock high");
endmodule
bind fmsp_serial_port fmsp_sva fmsp_sva_inst (.clock(clock), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q), .port3_bit0_out_q(port3_bit0_out_q),
  .port3_bit0_oe_n_q(port3_bit0_oe_n_q), .port3_bit1_out_q(port3_bit1_out_q));

/* test/tb.sv */
// self-checking testbench of the four-mode serial port
`timescale 1ns/1ps
`include "fmsp_regs.vh"
module tb;
  reg clock = 1'b0;
  reg reset = 1'b1;
  reg [7:0] sfr_addr = 8'h00;
  reg sfr_wr = 1'b0;
  reg sfr_rd = 1'b0;
  reg [7:0] sfr_wdata = 8'h00;
  reg tick = 1'b0;
  reg [1:0] div_q = 2'h0;
  wire [7:0] sfr_rdata_q;
  wire rxd_out;
  wire rxd_oe_n;
  wire txd;
  wire rxd_far;
  wire rxd = rxd_oe_n ? rxd_far : rxd_out;
  integer error_cnt = 0;
  integer samples_checked = 0;
  integer cyc = 0;
  integer m;
  integer f;
  integer n;
  reg [31:0] seed = 32'h55659516;
  reg [7:0] v;
  reg [7:0] d;
  reg [7:0] c;
  reg [7:0] p;
  reg [7:0] cap;
  fmsp_serial_port fmsp_serial_port_inst (.clock(clock), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q), .timer1_overflow(tick),
    .timer2_overflow(tick), .tx_timer_select(1'b1), .rx_timer_select(1'b0), .double_rate(1'b1),
    .port3_bit0_in(rxd), .port3_bit0_out_q(rxd_out), .port3_bit0_oe_n_q(rxd_oe_n), .port3_bit1_out_q(txd));
  fmsp_partner fmsp_partner_inst (.line(txd), .rxd_drive(rxd_far));
  initial begin
    forever #4 clock = ~clock;
  end
  // one tick feeds both timers: transmit on timer 2, receive on timer 1, same rate
  always @(posedge clock) begin
    div_q <= div_q + 2'h1;
    tick <= div_q == 2'h3;
    cyc = cyc + 1;
    if (cyc == 60000) begin
      error_cnt = error_cnt + 1;
      summarize;
    end
  end
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // expected control: flags and received ninth bit only when the frame is kept
  function [7:0] ctl_of(input [1:0] md, input fl, input nb, input dn);
    ctl_of = {md, fl, 1'b1, nb, nb & dn, 1'b0, dn};
  endfunction
  task wr(input [7:0] a, input [7:0] w);
    begin
      @(posedge clock);
      sfr_addr <= a;
      sfr_wdata <= w;
      sfr_wr <= 1'b1;
      @(posedge clock);
      sfr_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clock);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge clock);
      sfr_rd <= 1'b0;
      @(negedge clock);
      v = sfr_rdata_q;
    end
  endtask
  task chk(input [7:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (v !== e) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: got %h expected %h", $time, v, e);
      end
    end
  endtask
  // bounded poll of the control flags
  task poll(input [7:0] mask);
    begin
      n = 0;
      rd(`FMSP_ADDR_CONTROL);
      while ((v & mask) == 8'h00 && n < 600) begin
        rd(`FMSP_ADDR_CONTROL);
        n = n + 1;
      end
      // an exhausted poll is a mismatch in its own right
      if (n == 600) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: flag poll timed out", $time);
      end
    end
  endtask
  task summarize;
    begin
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
        $display("TEST PASSED");
      end else begin
        $display("TEST FAILED");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    wr(8'h9A, 8'hFF);
    rd(`FMSP_ADDR_CONTROL);
    chk(8'h00);
    rd(8'h9A);
    chk(8'h00);
    // mode 0 send, bits taken at each rising shift clock
    seed = xs(seed);
    d = seed[7:0];
    wr(`FMSP_ADDR_CONTROL, 8'h00);
    wr(`FMSP_ADDR_DATA, d);
    repeat (8) @(posedge txd) cap = {rxd_out, cap[7:1]};
    v = cap;
    chk(d);
    poll(8'h02);
    chk(8'h02);
    // mode 0 receive; received ninth bit is unused here so it is masked
    seed = xs(seed);
    p = seed[7:0];
    fmsp_partner_inst.m0_byte = p;
    fmsp_partner_inst.m0_idx = 3'h0;
    wr(`FMSP_ADDR_CONTROL, 8'h10);
    poll(8'h01);
    v = v & 8'hFB;
    chk(8'h11);
    rd(`FMSP_ADDR_DATA);
    chk(p);
    fmsp_partner_inst.m0_on = 1'b0;
    // uart modes with every filter and ninth-bit combination
    for (m = 1; m < 4; m = m + 1) begin
      fmsp_partner_inst.bit_ns = (m == 2) ? 256 : 512;
      for (f = 0; f < 4; f = f + 1) begin
        seed = xs(seed);
        d = seed[7:0];
        c = ctl_of(m[1:0], f[1], f[0], 1'b0);
        wr(`FMSP_ADDR_CONTROL, c);
        wr(`FMSP_ADDR_DATA, d);
        poll(8'h02);
        chk(c | 8'h02);
        // let the partner take its last sample after the stop bit
        repeat (80) @(posedge clock);
        v = fmsp_partner_inst.rx_word[7:0];
        chk(d);
        v = {6'h00, fmsp_partner_inst.rx_word[9:8]};
        chk({7'h01, m == 1 ? 1'b1 : f[0]});
        wr(`FMSP_ADDR_CONTROL, c);
        @(negedge clock);
        fmsp_partner_inst.send({f[0], ~d});
        repeat (40) @(posedge clock);
        rd(`FMSP_ADDR_CONTROL);
        chk(ctl_of(m[1:0], f[1], f[0], !f[1] || f[0]));
        rd(`FMSP_ADDR_DATA);
        chk((!f[1] || f[0]) ? ~d : p);
        p = v;
      end
    end
    // receive done still set: the late frame is dropped
    @(negedge clock);
    fmsp_partner_inst.send(9'h15A);
    repeat (40) @(posedge clock);
    rd(`FMSP_ADDR_DATA);
    chk(p);
    rd(`FMSP_ADDR_CONTROL);
    chk(ctl_of(2'h3, 1'b1, 1'b1, 1'b1));
    summarize;
  end
endmodule
